// file: design/pww_pkg.sv
// Package for the power, wake-up timer and watchdog unit.
// Assumes one 25 MHz system clock standing in for the always-on RC clock.
package pww_pkg;
    // Clock rate and timing
    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned TICK_MIN_US  = 300;
    localparam int unsigned TICK_MAX_MS  = 80;
    localparam int unsigned TICK_DEF_MS  = 10;
    localparam int unsigned TICK_MIN_CYC = (CLK_HZ / 1000000) * TICK_MIN_US;
    localparam int unsigned TICK_MAX_CYC = (CLK_HZ / 1000) * TICK_MAX_MS;
    localparam int unsigned TICK_DEF_CYC = (CLK_HZ / 1000) * TICK_DEF_MS;
    localparam int unsigned TICK_W       = 21;
    localparam int unsigned TMR_W        = 16;

    // Register byte addresses
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_TICK   = 4'h4;
    localparam logic [3:0] ADR_WAKE   = 4'h8;
    localparam logic [3:0] ADR_WDOG   = 4'hc;

    // Control register fields
    localparam int unsigned B_PDOWN   = 0;
    localparam int unsigned B_ADC     = 1;
    localparam int unsigned B_RADIO   = 2;
    localparam int unsigned B_XTAL    = 3;
    localparam int unsigned B_WK_A    = 4;
    localparam int unsigned B_WK_B    = 5;
    localparam int unsigned B_WT_RUN  = 6;
    localparam int unsigned B_WD_ON   = 7;
    localparam int unsigned B_BOOT    = 8;
    localparam int unsigned B_ASLEEP  = 9;
    localparam int unsigned B_WT_IRQ  = 10;
    localparam int unsigned B_WD_RST  = 11;
    localparam int unsigned B_OSC_ON  = 12;

    typedef enum logic [1:0] {PWW_RUN, PWW_DOWN} pww_state_t;
endpackage

// file: design/pww_top.sv
// Power-down control, wake-up timer and watchdog with Avalon-MM registers.
// Assumes synchronous wake pins and a processor that obeys halt_cpu.
//
// Function
// - Power-down entered only on software command
// - ADC and radio supplies switched separately
// - Processor halted; storage keeps its contents
// - RC clock, enabled timers keep running down
// - Enabled external pin wakes from power-down
// - Wake-up expiry or watchdog reset also wakes
// - RC oscillator cannot be turned off
// - Two separate 16-bit counters on RC clock
// - Tick programmable 300us to 80ms, 10ms default
// - Software starts and stops wake-up timer
// - Watchdog inactive after any reset
// - Active watchdog cannot be disabled again
// - Software gates crystal; processor clocked from it
// - Wake-up timer is an interrupt source
// - Boot loader runs after reset or request
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module pww_top
    import pww_pkg::*;
#(
    parameter int unsigned TICK_DEF = TICK_DEF_CYC
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_wake_pin_a_n,
    input  wire logic        ext_wake_pin_b_n,
    output logic             halt_cpu,
    output logic             xtal_en,
    output logic             cpu_clk_from_xtal,
    output logic             adc_pwr_en,
    output logic             radio_pwr_en,
    output logic             low_power_rc_clock_en,
    output logic             wake_timer_irq,
    output logic             boot_start,
    output logic             chip_reset_req
);
    pww_state_t        st_r, st_nxt;
    logic              ack_r, ack_nxt;
    logic [31:0]       rd_r, rd_nxt;
    logic              adc_r, adc_nxt, rad_r, rad_nxt, xt_r, xt_nxt;
    logic              wka_r, wka_nxt, wkb_r, wkb_nxt;
    logic              wtr_r, wtr_nxt, wd_r, wd_nxt;
    logic              irq_r, irq_nxt, boot_r, boot_nxt, wdr_r, wdr_nxt;
    logic [TICK_W-1:0] tdiv_r, tdiv_nxt, tcnt_r, tcnt_nxt;
    logic [TMR_W-1:0]  wtl_r, wtl_nxt, wtc_r, wtc_nxt;
    logic [TMR_W-1:0]  wdl_r, wdl_nxt, wdc_r, wdc_nxt;
    logic              tick, wr, rd, wake_pin, wt_exp, wd_exp;

    // Clamp a requested tick to the legal range
    function automatic logic [TICK_W-1:0] clamp_tick(input logic [31:0] v);
        if (v < TICK_MIN_CYC)
            return TICK_W'(TICK_MIN_CYC);
        else if (v > TICK_MAX_CYC)
            return TICK_W'(TICK_MAX_CYC);
        else
            return v[TICK_W-1:0];
    endfunction

    // Bus strobes: one wait cycle, then acknowledge
    assign wr              = avs_write && !ack_r;
    assign rd              = avs_read && !ack_r;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata    = rd_r;

    // Wake and expiry conditions
    assign wake_pin = (wka_r && !ext_wake_pin_a_n) || (wkb_r && !ext_wake_pin_b_n);
    assign wt_exp   = wtr_r && tick && (wtc_r == '0);
    assign wd_exp   = wd_r && tick && (wdc_r == '0);

    // Outputs
    // halt stops processor
    assign halt_cpu              = (st_r == PWW_DOWN);
    assign xtal_en               = xt_r;
    assign cpu_clk_from_xtal     = xt_r;
    assign adc_pwr_en            = adc_r;
    assign radio_pwr_en          = rad_r;
    assign low_power_rc_clock_en = 1'b1;
    assign wake_timer_irq        = irq_r;
    assign boot_start            = boot_r;
    assign chip_reset_req        = wdr_r;

    // Tick divider and timers
    always_comb
    begin
        tdiv_nxt = tdiv_r;
        tcnt_nxt = tcnt_r + 1'b1;
        tick     = (tcnt_r >= tdiv_r - 1'b1);
        wtl_nxt  = wtl_r;
        wdl_nxt  = wdl_r;
        wtc_nxt  = wtc_r;
        wdc_nxt  = wdc_r;
        wtr_nxt  = wtr_r;
        wd_nxt   = wd_r;
        if (tick)
            tcnt_nxt = '0;
        if (wr && avs_address == ADR_TICK && avs_byteenable[0])
            tdiv_nxt = clamp_tick(avs_writedata);
        if (wtr_r && tick)
            wtc_nxt = (wtc_r == '0) ? wtl_r : wtc_r - 1'b1;
        if (wd_r && tick)
            wdc_nxt = (wdc_r == '0) ? wdl_r : wdc_r - 1'b1;
        // Software reload wins over a tick in the same cycle
        if (wr && avs_address == ADR_WAKE)
        begin
            wtl_nxt = avs_writedata[TMR_W-1:0];
            wtc_nxt = avs_writedata[TMR_W-1:0];
        end
        if (wr && avs_address == ADR_WDOG)
        begin
            wdl_nxt = avs_writedata[TMR_W-1:0];
            wdc_nxt = avs_writedata[TMR_W-1:0];
        end
        if (wr && avs_address == ADR_CTRL && avs_byteenable[0])
        begin
            wtr_nxt = avs_writedata[B_WT_RUN];
            wd_nxt  = wd_r | avs_writedata[B_WD_ON];
        end
    end

    // Power state, supplies and bus
    always_comb
    begin
        st_nxt   = st_r;
        ack_nxt  = (avs_read || avs_write) && !ack_r;
        rd_nxt   = rd_r;
        adc_nxt  = adc_r;
        rad_nxt  = rad_r;
        xt_nxt   = xt_r;
        wka_nxt  = wka_r;
        wkb_nxt  = wkb_r;
        irq_nxt  = irq_r;
        boot_nxt = 1'b0;
        wdr_nxt  = wd_exp;
        if (wr && avs_address == ADR_CTRL)
        begin
            if (avs_byteenable[0])
            begin
                adc_nxt = avs_writedata[B_ADC];
                rad_nxt = avs_writedata[B_RADIO];
                xt_nxt  = avs_writedata[B_XTAL];
                wka_nxt = avs_writedata[B_WK_A];
                wkb_nxt = avs_writedata[B_WK_B];
                if (avs_writedata[B_PDOWN])
                    st_nxt = PWW_DOWN;
            end
            if (avs_byteenable[1])
            begin
                boot_nxt = avs_writedata[B_BOOT];
                if (avs_writedata[B_WT_IRQ])
                    irq_nxt = 1'b0;
            end
        end
        if (wt_exp)
            irq_nxt = 1'b1;
        if (st_r == PWW_DOWN && (wake_pin || wt_exp || wd_exp))
            st_nxt = PWW_RUN;
        if (rd)
        begin
            rd_nxt = '0;
            unique case (avs_address)
                ADR_CTRL:
                begin
                    rd_nxt[B_ADC]    = adc_r;
                    rd_nxt[B_RADIO]  = rad_r;
                    rd_nxt[B_XTAL]   = xt_r;
                    rd_nxt[B_WK_A]   = wka_r;
                    rd_nxt[B_WK_B]   = wkb_r;
                    rd_nxt[B_WT_RUN] = wtr_r;
                    rd_nxt[B_WD_ON]  = wd_r;
                    rd_nxt[B_ASLEEP] = (st_r == PWW_DOWN);
                    rd_nxt[B_WT_IRQ] = irq_r;
                    rd_nxt[B_OSC_ON] = 1'b1;
                end
                ADR_TICK: rd_nxt[TICK_W-1:0] = tdiv_r;
                ADR_WAKE: rd_nxt = {wtc_r, wtl_r};
                ADR_WDOG: rd_nxt = {wdc_r, wdl_r};
                default:  rd_nxt = '0;
            endcase
        end
    end

    // State registers; watchdog off, boot pulse at reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r   <= PWW_RUN;
            ack_r  <= 1'b0;
            rd_r   <= '0;
            adc_r  <= 1'b0;
            rad_r  <= 1'b0;
            xt_r   <= 1'b1;
            wka_r  <= 1'b0;
            wkb_r  <= 1'b0;
            wtr_r  <= 1'b0;
            wd_r   <= 1'b0;
            irq_r  <= 1'b0;
            boot_r <= 1'b1;
            wdr_r  <= 1'b0;
            tdiv_r <= TICK_W'(TICK_DEF);
            tcnt_r <= '0;
            wtl_r  <= '1;
            wtc_r  <= '1;
            wdl_r  <= '1;
            wdc_r  <= '1;
        end
        else
        begin
            st_r   <= st_nxt;
            ack_r  <= ack_nxt;
            rd_r   <= rd_nxt;
            adc_r  <= adc_nxt;
            rad_r  <= rad_nxt;
            xt_r   <= xt_nxt;
            wka_r  <= wka_nxt;
            wkb_r  <= wkb_nxt;
            wtr_r  <= wtr_nxt;
            wd_r   <= wd_nxt;
            irq_r  <= irq_nxt;
            boot_r <= boot_nxt;
            wdr_r  <= wdr_nxt;
            tdiv_r <= tdiv_nxt;
            tcnt_r <= tcnt_nxt;
            wtl_r  <= wtl_nxt;
            wtc_r  <= wtc_nxt;
            wdl_r  <= wdl_nxt;
            wdc_r  <= wdc_nxt;
        end
    end

    a_wdog_sticky: assert property (@(posedge clk) disable iff (reset)
        $past(wd_r) |-> wd_r) else $error("watchdog was disabled");
    a_wdog_reset: assert property (@(posedge clk) disable iff (reset)
        wd_exp |=> chip_reset_req) else $error("no reset on watchdog expiry");
    a_sleep_cmd: assert property (@(posedge clk) disable iff (reset)
        $rose(halt_cpu) |-> $past(wr && avs_address == ADR_CTRL && avs_byteenable[0]
        && avs_writedata[B_PDOWN])) else $error("sleep without command");
    a_pin_wake: assert property (@(posedge clk) disable iff (reset)
        (halt_cpu && wake_pin) |=> !halt_cpu) else $error("pin did not wake");
    a_timer_wake: assert property (@(posedge clk) disable iff (reset)
        (halt_cpu && wt_exp) |=> !halt_cpu && wake_timer_irq)
        else $error("timer did not wake");
    a_rc_on: assert property (@(posedge clk) disable iff (reset)
        low_power_rc_clock_en) else $error("RC clock off");
    a_tick_range: assert property (@(posedge clk) disable iff (reset)
        tdiv_r <= TICK_MAX_CYC) else $error("tick out of range");
    a_wdog_init: assert property (@(posedge clk)
        $fell(reset) |-> !wd_r) else $error("watchdog on after reset");
    a_xtal_clk: assert property (@(posedge clk) disable iff (reset)
        cpu_clk_from_xtal == xtal_en) else $error("clock not from crystal");
    a_supply_write: assert property (@(posedge clk) disable iff (reset)
        (wr && avs_address == ADR_CTRL && avs_byteenable[0]) |=>
        (adc_pwr_en == $past(avs_writedata[B_ADC]))
        && (radio_pwr_en == $past(avs_writedata[B_RADIO])))
        else $error("supply enable not written");
    a_xtal_write: assert property (@(posedge clk) disable iff (reset)
        (wr && avs_address == ADR_CTRL && avs_byteenable[0]) |=>
        xtal_en == $past(avs_writedata[B_XTAL])) else $error("crystal gate not written");
    a_sleep_hold: assert property (@(posedge clk) disable iff (reset)
        (halt_cpu && !wr) |=> $stable({adc_r, rad_r, xt_r, wka_r, wkb_r, wtl_r, wdl_r}))
        else $error("settings changed while halted");
    a_wt_hold: assert property (@(posedge clk) disable iff (reset)
        (!wtr_r && !(wr && avs_address == ADR_WAKE)) |=> $stable(wtc_r))
        else $error("stopped wake-up timer counted");
    a_irq_hold: assert property (@(posedge clk) disable iff (reset)
        (wake_timer_irq && !(wr && avs_address == ADR_CTRL && avs_byteenable[1]
        && avs_writedata[B_WT_IRQ])) |=> wake_timer_irq) else $error("interrupt lost");
endmodule // pww_top

// file: testbench/pww_far_side.sv
// Far-side model: two wake pins with pull-ups and a processor step counter.
// Assumes the bench sets the press requests by non-blocking assignment on clk.
`timescale 1ns/1ps
module pww_far_side (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        halt_cpu,
    input  wire logic        cpu_clk_from_xtal,
    input  wire logic        press_a,
    input  wire logic        press_b,
    output logic             pin_a_n,
    output logic             pin_b_n,
    output logic      [15:0] cpu_steps
);
    // Released pins sit at the pull-up level
    assign pin_a_n = ~press_a;
    assign pin_b_n = ~press_b;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cpu_steps <= 16'h0000;
        else if (!halt_cpu && cpu_clk_from_xtal)
            cpu_steps <= cpu_steps + 16'h0001;
    end
endmodule // pww_far_side

// file: testbench/pww_top_tb.sv
// Self-checking bench for the power, wake-up timer and watchdog unit.
// Assumes Avalon-MM with one wait cycle and a short default tick.
`timescale 1ns/1ps
module pww_top_tb;
    import pww_pkg::*;
    localparam int unsigned TD = 20;
    logic        clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, halt_cpu, xtal_en, cpu_clk_from_xtal, adc_pwr_en;
    logic        radio_pwr_en, low_power_rc_clock_en, wake_timer_irq, boot_start;
    logic        chip_reset_req, ext_wake_pin_a_n, ext_wake_pin_b_n;
    logic        press_a = 1'b0, press_b = 1'b0;
    logic [15:0] cpu_steps, steps;
    int          num_errors = 0, n_tests = 0, cyc = 0;

    pww_top #(.TICK_DEF(TD)) pww_top_inst (.clk, .reset, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .ext_wake_pin_a_n, .ext_wake_pin_b_n, .halt_cpu, .xtal_en, .cpu_clk_from_xtal,
        .adc_pwr_en, .radio_pwr_en, .low_power_rc_clock_en, .wake_timer_irq,
        .boot_start, .chip_reset_req);
    pww_far_side pww_far_side_inst (.clk, .reset, .halt_cpu, .cpu_clk_from_xtal,
        .press_a, .press_b, .pin_a_n(ext_wake_pin_a_n), .pin_b_n(ext_wake_pin_b_n),
        .cpu_steps);

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("Checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] b);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_write <= w;
        avs_read <= !w;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Bounded wait: 0 awake, 1 irq, 2 chip reset, 3 halted
    task automatic wait_on(input int sel, input int lim, input string nm);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++)
        begin
            @(posedge clk);
            hit = (sel == 0) ? halt_cpu === 1'b0 : (sel == 1) ? wake_timer_irq === 1'b1 :
                  (sel == 2) ? chip_reset_req === 1'b1 : halt_cpu === 1'b1;
        end
        chk(nm, hit, 1'b1);
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        chk("boot_rst", boot_start, 1'b1);
        reset <= 1'b0;
        xfer(0, ADR_CTRL, 0, 4'hf);
        chk("ctrl_rst", q & 32'h16fe, 32'h1008);
        chk("rc_on", low_power_rc_clock_en, 1'b1);
        chk("halt_rst", halt_cpu, 1'b0);
        xfer(0, ADR_TICK, 0, 4'hf);
        chk("tick_rst", q, 32'(TD));
        xfer(0, 4'h2, 0, 4'hf);
        chk("unmapped", q, 32'h0);
        $display("Test reset done");
        for (int i = 0; i < 8; i++)
        begin
            xfer(1, ADR_CTRL, 32'(i) << 1, 4'h3);
            chk("supply", {adc_pwr_en, radio_pwr_en, xtal_en, cpu_clk_from_xtal},
                {i[0], i[1], i[2], i[2]});
        end
        xfer(1, ADR_CTRL, 32'h100, 4'h2);
        chk("boot_sw", boot_start, 1'b1);
        $display("Test supplies done");
        xfer(1, ADR_CTRL, 32'h1b, 4'h3);
        wait_on(3, 4, "sleep_a");
        steps = cpu_steps;
        press_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk("pin_b_off", halt_cpu, 1'b1);
        chk("cpu_stop", cpu_steps, steps);
        press_a <= 1'b1;
        wait_on(0, 4, "wake_a");
        press_a <= 1'b0;
        press_b <= 1'b0;
        xfer(0, ADR_CTRL, 0, 4'hf);
        chk("kept", q & 32'h0a, 32'h0a);
        xfer(1, ADR_CTRL, 32'h2b, 4'h3);
        wait_on(3, 4, "sleep_b");
        press_b <= 1'b1;
        wait_on(0, 4, "wake_b");
        press_b <= 1'b0;
        $display("Test pins done");
        xfer(1, ADR_WAKE, 32'h2, 4'hf);
        xfer(0, ADR_WAKE, 0, 4'hf);
        chk("reload", q & 32'hffff, 32'h2);
        xfer(1, ADR_CTRL, 32'h49, 4'h3);
        wait_on(1, 200, "wt_irq");
        @(posedge clk);
        chk("wt_wake", halt_cpu, 1'b0);
        xfer(1, ADR_CTRL, 32'h8, 4'h3);
        xfer(1, ADR_CTRL, 32'h400, 4'h2);
        repeat (150) @(posedge clk);
        chk("wt_stop", wake_timer_irq, 1'b0);
        $display("Test wake timer done");
        xfer(1, ADR_CTRL, 32'h88, 4'h3);
        xfer(1, ADR_CTRL, 32'h8, 4'h3);
        xfer(0, ADR_CTRL, 0, 4'hf);
        chk("wd_stuck", q & 32'h80, 32'h80);
        xfer(1, ADR_WDOG, 32'h1, 4'hf);
        xfer(1, ADR_CTRL, 32'h89, 4'h3);
        wait_on(3, 4, "sleep_wd");
        wait_on(2, 100, "wd_reset");
        wait_on(0, 3, "wd_wake");
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        chk("boot_por", boot_start, 1'b1);
        reset <= 1'b0;
        xfer(0, ADR_CTRL, 0, 4'hf);
        chk("wd_off", q & 32'h80, 32'h0);
        $display("Test watchdog done");
        xfer(1, ADR_TICK, 0, 4'hf);
        xfer(0, ADR_TICK, 0, 4'hf);
        chk("tick_min", q, 32'(TICK_MIN_CYC));
        xfer(1, ADR_TICK, 32'(TICK_MAX_CYC + 1), 4'hf);
        xfer(0, ADR_TICK, 0, 4'hf);
        chk("tick_max", q, 32'(TICK_MAX_CYC));
        $display("Test tick done");
        finish_test();
    end
endmodule // pww_top_tb
